// ===== inc/cmp_ctrl_defs.svh
// Constants for the comparator output control block
`ifndef CMP_CTRL_DEFS_SVH
`define CMP_CTRL_DEFS_SVH
// Clock period in ps (200 MHz)
`define CLK_PERIOD_PS      5000
// Filter hold time, ns as printed
`define FILTER_HOLD_NS     20
// Filter hold in cycles, rounded down, at least one
`define FILTER_HOLD_CYC    ((`FILTER_HOLD_NS * 1000) / `CLK_PERIOD_PS)
`define FILTER_CNT_W       3
// Positive channel codes
`define PCH_PIN0           3'h0
`define PCH_PIN1           3'h1
`define PCH_DAC            3'h5
`define PCH_FVR            3'h6
`define PCH_AGND           3'h7
// Negative channel codes
`define NCH_PIN_MAX        3'h4
`define NCH_AGND           3'h7
// Reset value and negative pin count
`define SPEED_RESET        1'b1
`define NEG_PIN_COUNT      5
`endif

// ===== inc/cmp_ctrl_pkg.sv
// Types for the comparator output control block
package cmp_ctrl_pkg;
  // Control register zero bits
  typedef struct packed {
    logic enable;
    logic out_enable;
    logic polarity;
    logic filter;
    logic speed;
    logic hysteresis;
    logic sync;
  } cmp_control0_t;
  // Control register one bits
  typedef struct packed {
    logic       rise_irq_enable;
    logic       fall_irq_enable;
    logic [2:0] pos_channel_select;
    logic [2:0] neg_channel_select;
  } cmp_control1_t;
  // Analog mux select outputs
  typedef struct packed {
    logic       pin0;
    logic       pin1;
    logic       dac;
    logic       fvr;
    logic       agnd;
  } pos_route_t;
  typedef struct packed {
    logic [4:0] pins;
    logic       amp;
    logic       agnd;
  } neg_route_t;
endpackage

// ===== sim/analog_core_model.sv
// Behavioural model of the analog comparator core and its input nodes
`timescale 1ns/100ps
module analog_core_model (
  input  wire logic                     i_sys_clk,
  input  wire logic                     i_core_en,
  input  wire cmp_ctrl_pkg::pos_route_t i_pos_route,
  input  wire cmp_ctrl_pkg::neg_route_t i_neg_route,
  input  int                            i_vp [5],
  input  int                            i_vn [7],
  output logic                          o_core_out
);
  int   vp;              // Selected non-inverting level, -1 if open
  int   vn;              // Selected inverting level, -1 if open
  logic float_q = 1'b0;  // Wanders while a node floats
  // ==========================================================
  // Open node: a pattern that changes every cycle
  always @(posedge i_sys_clk) float_q <= ~float_q;
  // Pick the node levels through the select enables
  always_comb begin
    vp = -1;
    vn = -1;
    for (int i = 0; i < 5; i++) if (i_pos_route[i]) vp = i_vp[i];
    for (int i = 0; i < 7; i++) if (i_neg_route[i]) vn = i_vn[i];
  end
  // High when non-inverting node is above inverting node
  assign o_core_out = (!i_core_en || vp < 0 || vn < 0) ? float_q : (vp > vn);
endmodule

// ===== sim/comparator_output_control_tb.sv
// Self-checking bench for the comparator output control block
`timescale 1ns/100ps
module comparator_output_control_tb;
  logic                        i_sys_clk = 1'b0;  // System clock
  logic                        i_rst_n   = 1'b0;  // Reset, active low
  cmp_ctrl_pkg::cmp_control0_t c0        = 7'h04; // Speed set at start
  cmp_ctrl_pkg::cmp_control1_t c1        = 8'h00; // Irq and channels
  logic                        clr       = 1'b0;  // Flag clear
  logic                        tmr_clk   = 1'b1;  // Timer clock, stopped
  logic                        dir       = 1'b1;  // Pin direction
  logic                        latch     = 1'b0;  // Port latch
  logic                        pin_in    = 1'b0;  // Pin level
  logic                        ana       = 1'b0;  // Pin is analog
  logic [4:0]                  amp       = 5'h00; // Amplifier sharing
  int                          vp [5]    = '{0, 0, 0, 0, 0};
  int                          vn [7]    = '{0, 0, 0, 0, 0, 0, 0};
  logic                        core, st, mir, pout, poe, prd, gate, flg;
  logic                        cen, spd, hys;
  cmp_ctrl_pkg::pos_route_t    pos_r;    // Positive route
  cmp_ctrl_pkg::neg_route_t    neg_r;    // Negative route
  int                          n_errors = 0;
  int                          n_tests  = 0;
  logic [4:0]                  pexp [8] = '{5'h10, 5'h08, 5'h00, 5'h00, 5'h00, 5'h04, 5'h02, 5'h01};
  // ==========================================================
  // Clock
  always #2.5 i_sys_clk = ~i_sys_clk;
  comparator_output_control comparator_output_control_inst (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_control0(c0), .i_control1(c1),
    .i_irq_clear(clr), .i_analog_core_out(core), .i_timer_clk(tmr_clk),
    .i_pin_direction_bit(dir), .i_port_latch(latch), .i_pin_in(pin_in),
    .i_analog_select(ana), .i_amp_shared_en(amp), .o_cmp_result_status(st),
    .o_mirror_result_bit(mir), .o_pin_out(pout), .o_pin_oe(poe), .o_port_read(prd),
    .o_timer_gate(gate), .o_cmp_irq_flag(flg), .o_core_enable(cen),
    .o_speed_power_select(spd), .o_hysteresis_enable(hys), .o_pos_route(pos_r),
    .o_neg_route(neg_r));
  analog_core_model analog_core_model_inst (
    .i_sys_clk(i_sys_clk), .i_core_en(cen), .i_pos_route(pos_r), .i_neg_route(neg_r),
    .i_vp(vp), .i_vn(vn), .o_core_out(core));
  // ==========================================================
  // Compare and count
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // Verdict and stop
  task automatic end_sim();
    if (n_errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Step to later falling edges
  task automatic cyc(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask
  // Bounded wait for the status bit
  task automatic wait_st(input logic v);
    for (int k = 0; k < 12 && st !== v; k++) cyc(1);
    chk("status", st, v);
    if (st !== v) end_sim();
  endtask
  // One-cycle spike on the non-inverting pin
  task automatic spike();
    vp[4] = 900;
    cyc(1);
    vp[4] = 100;
  endtask
  // ==========================================================
  initial begin
    cyc(20);
    i_rst_n = 1'b1;
    cyc(1);
    chk("speed", spd, 1'b1);
    chk("rst_status", st, 1'b0);
    c0.speed = 1'b0;
    c0.hysteresis = 1'b1;
    cyc(2);
    chk("speed0", spd, 1'b0);
    chk("hyst", hys, 1'b1);
    chk("pos_off", pos_r, 5'h00);
    c0.enable = 1'b1;
    cyc(2);
    chk("core_en", cen, 1'b1);
    for (int p = 0; p < 8; p++) begin
      c1.pos_channel_select = p[2:0];
      cyc(2);
      chk("pos_rt", pos_r, pexp[p]);
    end
    for (int q = 0; q < 8; q++) begin
      c1.neg_channel_select = q[2:0];
      cyc(2);
      chk("neg_rt", neg_r, q < 5 ? 7'h04 << q : (q == 7 ? 7'h01 : 7'h00));
    end
    amp = 5'h02;
    c1.neg_channel_select = 3'h1;
    cyc(2);
    chk("amp_rt", neg_r, 7'h02);
    // Pins set analog and input before use
    ana = 1'b1;
    pin_in = 1'b1;
    c1 = 8'h00;
    vp[4] = 500;
    vn[2] = 200;
    wait_st(1'b1);
    chk("mirror", mir, 1'b1);
    chk("gate", gate, 1'b1);
    chk("port_an", prd, 1'b0);
    c0.polarity = 1'b1;
    wait_st(1'b0);
    chk("mirror0", mir, 1'b0);
    vp[4] = 100;
    wait_st(1'b1);
    ana = 1'b0;
    latch = 1'b1;
    dir = 1'b0;
    cyc(4);
    chk("port_dig", prd, 1'b1);
    chk("pin_latch", pout, 1'b1);
    chk("pin_oe", poe, 1'b1);
    tmr_clk = 1'b0;
    cyc(4);
    tmr_clk = 1'b1;
    cyc(4);
    // Timer gating wanted synchronised
    c0.sync = 1'b1;
    c0.polarity = 1'b0;
    wait_st(1'b0);
    chk("gate_hold", gate, 1'b1);
    tmr_clk = 1'b0;
    cyc(6);
    chk("gate_sync", gate, 1'b0);
    c0.out_enable = 1'b1;
    cyc(2);
    chk("pin_res", pout, 1'b0);
    // Rising interrupt enable set, edges from disabled comparator
    c1.rise_irq_enable = 1'b1;
    c0.enable = 1'b0;
    c0.polarity = 1'b1;
    wait_st(1'b1);
    chk("pin_off", pout, 1'b0);
    cyc(1);
    chk("flag_rise", flg, 1'b1);
    clr = 1'b1;
    cyc(1);
    clr = 1'b0;
    cyc(1);
    chk("flag_clr", flg, 1'b0);
    c0.polarity = 1'b0;
    wait_st(1'b0);
    cyc(2);
    chk("flag_nofall", flg, 1'b0);
    c1.fall_irq_enable = 1'b1;
    c1.rise_irq_enable = 1'b0;
    c0.enable = 1'b1;
    c0.filter = 1'b1;
    spike();
    wait_st(1'b1);
    cyc(3);
    chk("filt_hold", st, 1'b1);
    chk("flag_norise", flg, 1'b0);
    wait_st(1'b0);
    chk("flag_fall", flg, 1'b1);
    c0.filter = 1'b0;
    spike();
    wait_st(1'b1);
    cyc(2);
    chk("filt_off", st, 1'b0);
    end_sim();
  end
endmodule

// ===== verilog/cmp_glitch_filter.sv
// Anti-oscillation hold filter on the comparator result
`timescale 1ns/100ps
`include "cmp_ctrl_defs.svh"
module cmp_glitch_filter (
  input  wire logic i_sys_clk,
  input  wire logic i_rst_n,
  input  wire logic i_enable,
  input  wire logic i_raw,
  output logic      o_filt
);
  // ==========================================
  // Hold counter
  localparam logic [`FILTER_CNT_W-1:0] HOLD =
    (`FILTER_HOLD_CYC < 1) ? `FILTER_CNT_W'(1) : `FILTER_CNT_W'(`FILTER_HOLD_CYC);
  logic [`FILTER_CNT_W-1:0] hold_reg;    // Cycles left blocking reversal
  logic                     out_reg;     // Filtered value
  wire                      blocked = (hold_reg != '0);
  wire                      change  = (i_raw != out_reg);
  // Filtered output register
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      out_reg  <= 1'b0;
      hold_reg <= '0;
    end else if (!i_enable) begin
      // Bypass: follow the raw value
      out_reg  <= i_raw;
      hold_reg <= '0;
    end else if (change && !blocked) begin
      // Accept change, then block reversal
      out_reg  <= i_raw;
      hold_reg <= HOLD;
    end else if (blocked) begin
      hold_reg <= hold_reg - `FILTER_CNT_W'(1);
    end
  end
  assign o_filt = i_enable ? out_reg : i_raw;
  // ==========================================
  // Checks
  a_hold_blocks: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_enable && $past(i_enable) && blocked && $past(blocked)) |-> $stable(out_reg))
    else $error("Filter reversed during hold");
endmodule

// ===== verilog/comparator_output_control.sv
// Comparator digital control, output routing and edge flag logic
`timescale 1ns/100ps
`include "cmp_ctrl_defs.svh"
// Behaviour
// - Result readable as status and mirror bit
// - Pin driven with output enable, direction, enable
// - Output enable overrides port latch, regardless enable
// - Internal result registered each cycle
// - Polarity invert swaps result sense
// - Speed select resets to one
// - Hysteresis bit switches hysteresis
// - Result offered as timer gate source
// - Sync captures on timer clock falling edge
// - Timer counts on opposite, rising edge
// - Enabled edge detectors set interrupt flag
// - Flag cleared by software; set wins
// - Polarity or enable toggles can flag
// - Positive field routes pin, DAC, reference, ground
// - Disabled comparator disconnects all inputs
// - Negative field routes pin or ground
// - Shared pin with amplifier routes amplifier
// - Filter blocks reversal for 20 ns
// - Analog pins read as zero
// - Disabled comparator result forced to the polarity bit
// - Positive channel code decoding
// - Negative channel code decoding
// - Filter enable applies or bypasses filter
module comparator_output_control (
  input  wire logic                        i_sys_clk,
  input  wire logic                        i_rst_n,
  input  wire cmp_ctrl_pkg::cmp_control0_t i_control0,
  input  wire cmp_ctrl_pkg::cmp_control1_t i_control1,
  input  wire logic                        i_irq_clear,
  input  wire logic                        i_analog_core_out,
  input  wire logic                        i_timer_clk,
  input  wire logic                        i_pin_direction_bit,
  input  wire logic                        i_port_latch,
  input  wire logic                        i_pin_in,
  input  wire logic                        i_analog_select,
  input  wire logic [4:0]                  i_amp_shared_en,
  output logic                             o_cmp_result_status,
  output logic                             o_mirror_result_bit,
  output logic                             o_pin_out,
  output logic                             o_pin_oe,
  output logic                             o_port_read,
  output logic                             o_timer_gate,
  output logic                             o_cmp_irq_flag,
  output logic                             o_core_enable,
  output logic                             o_speed_power_select,
  output logic                             o_hysteresis_enable,
  output cmp_ctrl_pkg::pos_route_t         o_pos_route,
  output cmp_ctrl_pkg::neg_route_t         o_neg_route
);
  // ==========================================
  // Input synchronisers
  logic [1:0] core_sync_reg;   // Analog result sync chain
  logic [1:0] tclk_sync_reg;   // Timer clock sync chain
  logic       tclk_prev_reg;   // Previous synced timer clock
  logic [1:0] pin_sync_reg;    // Pin input sync chain
  // Two flops per asynchronous input
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      core_sync_reg <= 2'h0;
      tclk_sync_reg <= 2'h0;
      pin_sync_reg  <= 2'h0;
      tclk_prev_reg <= 1'b0;
    end else begin
      core_sync_reg <= {core_sync_reg[0], i_analog_core_out};
      tclk_sync_reg <= {tclk_sync_reg[0], i_timer_clk};
      pin_sync_reg  <= {pin_sync_reg[0], i_pin_in};
      tclk_prev_reg <= tclk_sync_reg[1];
    end
  end
  // ==========================================
  // Result path
  wire en        = i_control0.enable;
  wire core_val  = core_sync_reg[1];
  // Disabled forces zero; polarity applied after
  wire gated     = en & core_val;
  wire polarized = gated ^ i_control0.polarity;
  wire filt;
  // Filter stage
  cmp_glitch_filter u_filter (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_enable  (i_control0.filter),
    .i_raw     (polarized),
    .o_filt    (filt)
  );
  logic result_reg;   // Result latched each cycle
  logic prev_reg;     // Previous result for edge detection
  logic sync_reg;     // Timer synchronised result
  logic flag_reg;     // Sticky interrupt flag
  wire  tclk_fall = tclk_prev_reg & ~tclk_sync_reg[1];
  // Internal result registered once per cycle
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      result_reg <= 1'b0;
      prev_reg   <= 1'b0;
    end else begin
      result_reg <= filt;
      prev_reg   <= result_reg;
    end
  end
  // Capture on falling timer clock edge; timer counts on rising
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync_reg <= 1'b0;
    end else if (tclk_fall) begin
      sync_reg <= result_reg;
    end
  end
  // ==========================================
  // Edge detection and flag
  wire rise      = result_reg & ~prev_reg;
  wire fall      = ~result_reg & prev_reg;
  wire edge_hit  = (rise & i_control1.rise_irq_enable)
                 | (fall & i_control1.fall_irq_enable);
  wire flag_next = edge_hit | (flag_reg & ~i_irq_clear);
  // Set wins over a same-cycle clear
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end
  // ==========================================
  // Output and mux decode
  wire ext_val   = i_control0.sync ? sync_reg : result_reg;
  // Override applies with output enable alone; result only shown while enabled
  wire pin_res   = ext_val & en;
  wire pin_val   = i_control0.out_enable ? pin_res : i_port_latch;
  wire pin_drive = ~i_pin_direction_bit;
  wire pin_rd    = i_analog_select ? 1'b0 : pin_sync_reg[1];
  wire [2:0] pch = i_control1.pos_channel_select;
  wire [2:0] nch = i_control1.neg_channel_select;
  cmp_ctrl_pkg::pos_route_t pos_next;
  cmp_ctrl_pkg::neg_route_t neg_next;
  // Positive route, all off when disabled
  assign pos_next.pin0 = en & (pch == `PCH_PIN0);
  assign pos_next.pin1 = en & (pch == `PCH_PIN1);
  assign pos_next.dac  = en & (pch == `PCH_DAC);
  assign pos_next.fvr  = en & (pch == `PCH_FVR);
  assign pos_next.agnd = en & (pch == `PCH_AGND);
  // Negative route per pin; shared pin gives amplifier
  genvar gi;
  logic [4:0] amp_hit;
  generate
    for (gi = 0; gi < `NEG_PIN_COUNT; gi++) begin : g_neg
      wire sel = en & (nch == 3'(gi));
      assign neg_next.pins[gi] = sel & ~i_amp_shared_en[gi];
      assign amp_hit[gi]       = sel & i_amp_shared_en[gi];
    end
  endgenerate
  assign neg_next.amp  = |amp_hit;
  assign neg_next.agnd = en & (nch == `NCH_AGND);
  // Output registers
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cmp_result_status  <= 1'b0;
      o_mirror_result_bit  <= 1'b0;
      o_pin_out            <= 1'b0;
      o_pin_oe             <= 1'b0;
      o_port_read          <= 1'b0;
      o_timer_gate         <= 1'b0;
      o_cmp_irq_flag       <= 1'b0;
      o_core_enable        <= 1'b0;
      o_speed_power_select <= `SPEED_RESET;
      o_hysteresis_enable  <= 1'b0;
      o_pos_route          <= '0;
      o_neg_route          <= '0;
    end else begin
      o_cmp_result_status  <= result_reg;
      o_mirror_result_bit  <= result_reg;
      o_pin_out            <= pin_val;
      o_pin_oe             <= pin_drive;
      o_port_read          <= pin_rd;
      o_timer_gate         <= ext_val;
      o_cmp_irq_flag       <= flag_next;
      o_core_enable        <= en;
      o_speed_power_select <= i_control0.speed;
      o_hysteresis_enable  <= i_control0.hysteresis;
      o_pos_route          <= pos_next;
      o_neg_route          <= neg_next;
    end
  end
  // ==========================================
  // Checks
  a_disabled_zero: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (!en && !i_control0.polarity && !i_control0.filter) [*3] |=> !result_reg)
    else $error("Result not zero while disabled");
  a_flag_set_wins: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    edge_hit |=> flag_reg)
    else $error("Edge lost on flag");
  a_flag_sticky: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (flag_reg && !i_irq_clear) |=> flag_reg)
    else $error("Flag dropped without clear");
  a_rise_flag: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    ($rose(result_reg) && i_control1.rise_irq_enable) |=> o_cmp_irq_flag)
    else $error("Rising edge did not flag");
  a_no_route_off: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !en |=> (o_pos_route == '0) && (o_neg_route == '0))
    else $error("Inputs routed while disabled");
  a_analog_read: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_analog_select |=> !o_port_read)
    else $error("Analog pin read nonzero");
  a_status_mirror: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_cmp_result_status == o_mirror_result_bit)
    else $error("Mirror differs from status");
  a_sync_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !tclk_fall |=> $stable(sync_reg))
    else $error("Sync result moved off falling edge");

  // ==========================================
  // Checks on outputs and routing

  // Pin shows zero while disabled under override
  a_pin_masked: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_control0.out_enable && !en) |=> !o_pin_out)
    else $error("Pin shows result while disabled");

  // Pin driver follows the direction bit
  a_oe_dir: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    1'b1 |=> (o_pin_oe == !$past(i_pin_direction_bit)))
    else $error("Pin driver does not follow direction");

  // Without override the port latch reaches the pin
  a_latch_pass: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !i_control0.out_enable |=> (o_pin_out == $past(i_port_latch)))
    else $error("Port latch not on pin");

  // Status follows the registered result
  a_status_reg: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    1'b1 |=> (o_cmp_result_status == $past(result_reg)))
    else $error("Status not from registered result");

  // Speed select copied to the core
  a_speed_copy: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    1'b1 |=> (o_speed_power_select == $past(i_control0.speed)))
    else $error("Speed select not passed on");

  // Hysteresis select copied to the core
  a_hyst_copy: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    1'b1 |=> (o_hysteresis_enable == $past(i_control0.hysteresis)))
    else $error("Hysteresis select not passed on");

  // Unsynchronised gate follows the result
  a_gate_async: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !i_control0.sync |=> (o_timer_gate == $past(result_reg)))
    else $error("Timer gate not the result");

  // Falling timer clock captures the result
  a_sync_capture: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    tclk_fall |=> (sync_reg == $past(result_reg)))
    else $error("Sync result not captured");

  // Falling result edge sets the flag when enabled
  a_fall_flag: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    ($fell(result_reg) && i_control1.fall_irq_enable) |=> o_cmp_irq_flag)
    else $error("Falling edge did not flag");

  // Disabled result equals the polarity bit
  a_disabled_pol: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (!en && !i_control0.filter) |=> (result_reg == $past(i_control0.polarity)))
    else $error("Disabled result ignores polarity");

  // Shared pin with amplifier selects amplifier
  a_amp_route: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (en && (nch < 3'h5) && i_amp_shared_en[nch]) |=> o_neg_route.amp)
    else $error("Amplifier not routed");

  // Digital pin reads the synchronised level
  a_port_digital: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !i_analog_select |=> (o_port_read == $past(pin_sync_reg[1])))
    else $error("Digital pin read wrong");

  // At most one positive source connected
  a_pos_onehot: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    $onehot0(o_pos_route))
    else $error("Several positive sources routed");

  // DAC code selects the DAC
  a_route_dac: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (en && (pch == `PCH_DAC)) |=> o_pos_route.dac)
    else $error("DAC not routed");

  // At most one negative source connected
  a_neg_onehot: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    $onehot0(o_neg_route))
    else $error("Several negative sources routed");

  // Ground code selects analog ground
  a_route_agnd: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (en && (nch == `NCH_AGND)) |=> o_neg_route.agnd)
    else $error("Ground not routed");

  // Scenario covers
  c_sync_cap: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    tclk_fall && i_control0.sync);
  c_rise: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n) rise && flag_next);
  c_fall: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n) fall && flag_next);
  c_clear_race: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    edge_hit && i_irq_clear && flag_reg);
endmodule
